/* dv/lpddr_ctrl_model.sv */
/*
 * Command-bus driver standing in for the memory controller.
 * Assumes one command slot per pclk cycle and a caller that runs
 * the bring-up right after reset or deep power down.
 */
`timescale 1ns/1ps
`default_nettype none
module lpddr_ctrl_model #(
   parameter int AW = 14
) (
   input wire logic pclk,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic bank_select_low,
   output logic bank_select_high,
   output logic [AW-1:0] addr
);
   initial begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'h7;
      {bank_select_high, bank_select_low} = 2'h0;
      addr = '0;
   end
   // lines left idle flip so a stale value is never mistaken for a command
   task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                      input logic [AW-1:0] a);
      @(posedge pclk);
      {cs_n, ras_n, cas_n, we_n} <= c;
      {bank_select_high, bank_select_low} <= b;
      addr <= a;
      @(posedge pclk);
      {cs_n, ras_n, cas_n, we_n} <= 4'h7;
      {bank_select_high, bank_select_low} <= ~b;
      addr <= ~a;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // clock enable is dropped only to show that commands need it high
   task automatic set_cke(input logic v);
      @(posedge pclk);
      cke <= v;
   endtask
   // waits between commands kept although the device does not time them; the first covers its settle count
   task automatic init(input logic [AW-1:0] mode);
      idle(12);
      cmd(4'h2, 2'h0, AW'(14'h0400));
      idle(3);
      cmd(4'h1, 2'h0, '0);
      idle(4);
      cmd(4'h1, 2'h0, '0);
      idle(4);
      cmd(4'h0, 2'h0, mode);
      idle(3);
      cmd(4'h0, 2'h2, AW'(14'h0020));
      idle(3);
   endtask
endmodule // lpddr_ctrl_model
`default_nettype wire

/* dv/lpddr_init_mode_burst_test.sv */
/*
 * Self-checking bench: APB master, column sink and scenario tasks.
 * Assumes the device raises pready; only the watchdog bounds that wait.
 */
`timescale 1ns/1ps
`default_nettype none
module lpddr_init_mode_burst_test;
   logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic cke, cs_n, ras_n, cas_n, we_n, bsl, bsh;
   logic [13:0] addr;
   logic col_valid, col_ready, col_write;
   logic [1:0] col_bank;
   logic [9:0] col_addr;
   logic [12:0] exp_q[$];
   int bad_count = 0;
   int n_compared = 0;

   lpddr_init_mode_burst #(.SETTLE_CYCLES(8)) i_dut (.pclk(pclk),
      .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .bank_select_low(bsl),
      .bank_select_high(bsh), .addr(addr), .col_valid(col_valid),
      .col_ready(col_ready), .col_write(col_write), .col_bank(col_bank),
      .col_addr(col_addr));
   lpddr_ctrl_model #(.AW(14)) i_ctrl (.pclk(pclk), .cke(cke),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .bank_select_low(bsl), .bank_select_high(bsh), .addr(addr));

   task automatic report_and_stop;
      $display("compared %0d, mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic e);
      logic [31:0] r;
      logic er;
      apb(1'b0, a, 32'h0, r, er);
      chk(r, d);
      chk(32'(er), 32'(e));
   endtask
   function automatic void expect_burst(logic w, logic [1:0] b,
                                        int s, int len, logic il);
      int c;
      for (int i = 0; i < len; i++) begin
         c = il ? ((s ^ i) & (len - 1)) : ((s + i) & (len - 1));
         exp_q.push_back({w, b, 10'((s & ~(len - 1)) | c)});
      end
   endfunction
   // beats are looked at mid-cycle, taken at the next rising edge
   task automatic drain(input int n);
      int k;
      k = 0;
      col_ready <= 1'b1;
      while (n > 0 && k < 400) begin
         @(negedge pclk);
         k++;
         if (col_valid === 1'b1) begin
            chk(32'({col_write, col_bank, col_addr}),
                32'(exp_q.pop_front()));
            n--;
         end
      end
      chk(n, 0);
      @(posedge pclk);
      col_ready <= 1'b0;
   endtask
   task automatic t_early;
      i_ctrl.cmd(4'h1, 2'h0, '0);
      i_ctrl.idle(12);
      i_ctrl.cmd(4'h5, 2'h0, '0);
      i_ctrl.idle(3);
      rd(lpddr_pkg::OFS_STATUS, 32'h0000_00C0, 1'b0);
      wr(lpddr_pkg::OFS_STATUS, 32'h0000_01C0);
      rd(lpddr_pkg::OFS_STATUS, 32'h0000_0000, 1'b0);
   endtask
   task automatic t_regs;
      rd(lpddr_pkg::OFS_MODE, 32'h0000_0000, 1'b0);
      rd(lpddr_pkg::OFS_EXT, 32'h0000_0000, 1'b0);
      rd(8'h10, 32'h0000_0000, 1'b1);
      wr(lpddr_pkg::OFS_MODE, 32'h0000_0033);
      rd(lpddr_pkg::OFS_MODE, 32'h0000_0000, 1'b0);
   endtask
   task automatic t_init(input logic [13:0] m);
      i_ctrl.init(m);
      i_ctrl.cmd(4'h0, 2'h1, 14'h0077);
      i_ctrl.idle(3);
      rd(lpddr_pkg::OFS_MODE, 32'(m), 1'b0);
      rd(lpddr_pkg::OFS_EXT, 32'h0000_0020, 1'b0);
      rd(lpddr_pkg::OFS_STATUS, 32'h0000_002F, 1'b0);
   endtask
   task automatic t_burst;
      for (int c = 1; c <= 4; c++) begin
         for (int il = 0; il < 2; il++) begin
            i_ctrl.cmd(4'h0, 2'h0, 14'(8'h30 | (il << 3) | c));
            i_ctrl.idle(3);
            rd(lpddr_pkg::OFS_MODE, 32'h30 | (il << 3) | c, 1'b0);
            expect_burst(1'b0, 2'h2, 10'h1AD, 1 << c, 1'(il));
            i_ctrl.cmd(4'h5, 2'h2, 14'h01AD);
            drain(1 << c);
         end
      end
   endtask
   // commands with clock enable low are ignored; reserved length refused
   task automatic t_gate;
      i_ctrl.set_cke(1'b0);
      i_ctrl.cmd(4'h5, 2'h0, 14'h0001);
      i_ctrl.cmd(4'h0, 2'h0, 14'h0011);
      i_ctrl.set_cke(1'b1);
      i_ctrl.idle(3);
      rd(lpddr_pkg::OFS_MODE, 32'h0000_003C, 1'b0);
      rd(lpddr_pkg::OFS_STATUS, 32'h0000_002F, 1'b0);
      chk(32'(col_valid), 32'h0);
      i_ctrl.cmd(4'h0, 2'h0, 14'h0035);
      i_ctrl.idle(3);
      i_ctrl.cmd(4'h5, 2'h0, 14'h0001);
      i_ctrl.idle(3);
      rd(lpddr_pkg::OFS_STATUS, 32'h0000_006F, 1'b0);
      wr(lpddr_pkg::OFS_STATUS, 32'h0000_0040);
      rd(lpddr_pkg::OFS_STATUS, 32'h0000_002F, 1'b0);
   endtask
   // third burst overfills the fifo and stalls; a fourth is dropped
   task automatic t_fifo;
      i_ctrl.cmd(4'h0, 2'h0, 14'h0034);
      i_ctrl.idle(3);
      expect_burst(1'b1, 2'h1, 10'h005, 16, 1'b0);
      i_ctrl.cmd(4'h4, 2'h1, 14'h0005);
      i_ctrl.idle(24);
      expect_burst(1'b0, 2'h3, 10'h01A, 16, 1'b0);
      i_ctrl.cmd(4'h5, 2'h3, 14'h001A);
      i_ctrl.idle(24);
      expect_burst(1'b0, 2'h0, 10'h3F0, 16, 1'b0);
      i_ctrl.cmd(4'h5, 2'h0, 14'h03F0);
      i_ctrl.idle(24);
      rd(lpddr_pkg::OFS_STATUS, 32'h0000_022F, 1'b0);
      i_ctrl.cmd(4'h5, 2'h0, 14'h0001);
      i_ctrl.idle(3);
      rd(lpddr_pkg::OFS_STATUS, 32'h0000_032F, 1'b0);
      wr(lpddr_pkg::OFS_STATUS, 32'h0000_0100);
      drain(48);
      rd(lpddr_pkg::OFS_STATUS, 32'h0000_002F, 1'b0);
   endtask
   task automatic t_dpd;
      wr(lpddr_pkg::OFS_CTRL, 32'h0000_0001);
      rd(lpddr_pkg::OFS_EXT, 32'h0000_0000, 1'b0);
      rd(lpddr_pkg::OFS_MODE, 32'h0000_0000, 1'b0);
      rd(lpddr_pkg::OFS_STATUS, 32'h0000_0000, 1'b0);
      rd(lpddr_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
      t_init(14'h0023);
   endtask

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      #(40 * 20000);
      bad_count++;
      report_and_stop;
   end
   initial begin
      {presetn, psel, penable, pwrite, col_ready} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_early;
      t_regs;
      t_init(14'h0032);
      t_burst;
      t_gate;
      t_fifo;
      t_dpd;
      report_and_stop;
   end
endmodule // lpddr_init_mode_burst_test
`default_nettype wire

/* logic/lpddr_col_fifo.sv */
/*
 * Column-address fifo with registered read data.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module lpddr_col_fifo #(
   parameter int W = 13,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two");
   end
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic ov_q, ov_d;
   logic [W-1:0] od_q;
   logic push, pop;

   always_comb begin
      in_ready = cnt_q != (AW+1)'(DEPTH);
      push = in_valid && in_ready;
      // output stage refills whenever it is empty or being taken
      pop = (cnt_q != '0) && (!ov_q || out_ready);
      wp_d = wp_q + AW'(push);
      rp_d = rp_q + AW'(pop);
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         ov_q <= 1'b0;
         od_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         ov_q <= ov_d;
         if (pop) begin
            od_q <= mem_q[rp_q];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   assign out_valid = ov_q;
   assign out_data = od_q;
endmodule // lpddr_col_fifo
`default_nettype wire

/* logic/lpddr_init_mode_burst.sv */
/*
 * Memory-side tracking of the power-up sequence, base and extended mode
 * registers, and burst column ordering. Burst columns leave through a
 * fifo. Assumes the command pins are asynchronous to pclk and that each
 * pclk cycle carries one command slot.
 */
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Device accepts reads and writes only after the whole init sequence.
// - Mode registers have no default; both must be programmed.
// - Mode set with both bank bits low loads base register, held.
// - Base register: bits 0-2 burst length, 3 type, 4-6 latency.
// - Burst lengths 2, 4, 8 and 16, sequential or interleaved.
// - Burst stays in an aligned block of burst length, wrapping.
// - Low column bits give the first beat; same length read and write.
// - Sequential order adds one per beat modulo the length, also 16.
// - Interleaved order takes start offset xor beat index.
// - Type bit picks the order; length sixteen uses bits four and up.
module lpddr_init_mode_burst #(
   parameter int ADDR_W = 14,
   parameter int COL_W = 10,
   parameter int SETTLE_CYCLES = lpddr_pkg::SETTLE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   input wire logic [ADDR_W-1:0] addr,
   output logic col_valid,
   input wire logic col_ready,
   output logic col_write,
   output logic [1:0] col_bank,
   output logic [COL_W-1:0] col_addr
);
   localparam int PW = ADDR_W + 7;
   localparam int FW = COL_W + 3;
   localparam int SW = $clog2(SETTLE_CYCLES + 1);
   if (COL_W < 4 || ADDR_W < 11 || ADDR_W > 32) begin : g_bad_width
      $error("address widths out of range");
   end

   typedef enum logic {init_cold, init_ready} init_e;
   typedef enum logic {burst_idle, burst_run} burst_e;

   function automatic logic [4:0] bl_len(input logic [2:0] code);
      case (code)
         lpddr_pkg::BL_2: bl_len = 5'h02;
         lpddr_pkg::BL_4: bl_len = 5'h04;
         lpddr_pkg::BL_8: bl_len = 5'h08;
         lpddr_pkg::BL_16: bl_len = 5'h10;
         default: bl_len = 5'h00;
      endcase
   endfunction

   function automatic logic [3:0] off_mask(input logic [4:0] len);
      off_mask = 4'(len - 5'h01);
   endfunction

   // column of beat i inside the aligned block of the start column
   function automatic logic [COL_W-1:0] beat_col(
      input logic [COL_W-1:0] s, input logic [4:0] len,
      input logic ilv, input logic [3:0] i);
      logic [3:0] m;
      logic [3:0] off;
      m = off_mask(len);
      off = ilv ? (s[3:0] ^ i) : 4'(s[3:0] + i);
      beat_col = (s & ~COL_W'(m)) | COL_W'(off & m);
   endfunction

   // pin synchroniser
   logic [PW-1:0] pin_meta_q, pin_sync_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= {cke, cs_n, ras_n, cas_n, we_n,
                        bank_select_high, bank_select_low, addr};
         pin_sync_q <= pin_meta_q;
      end
   end

   logic cmd_cke, cmd_cs_n, cmd_ras_n, cmd_cas_n, cmd_we_n, cmd_bsh, cmd_bsl;
   logic [ADDR_W-1:0] cmd_addr;
   logic [COL_W-1:0] cmd_col;
   assign {cmd_cke, cmd_cs_n, cmd_ras_n, cmd_cas_n, cmd_we_n,
           cmd_bsh, cmd_bsl, cmd_addr} = pin_sync_q;
   assign cmd_col = cmd_addr[COL_W-1:0];

   // state
   logic [SW-1:0] settle_q, settle_d;
   init_e init_q, init_d;
   burst_e burst_q, burst_d;
   logic pre_q, pre_d, base_q, base_d, ext_q, ext_d;
   logic [1:0] ref_q, ref_d;
   logic [ADDR_W-1:0] mode_q, mode_d, emode_q, emode_d;
   logic reject_q, reject_d, early_q, early_d, overrun_q, overrun_d;
   logic [COL_W-1:0] start_q, start_d;
   logic [1:0] bank_q, bank_d;
   logic wr_q, wr_d, ilv_q, ilv_d;
   logic [4:0] blen_q, blen_d;
   logic [3:0] beat_q, beat_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;

   logic settled, busy_cmd, is_rw, mode_base_w, mode_ext_w, dpd_w;
   logic start_burst, push_w, fifo_in_ready, apb_wr, st_clr;
   logic [COL_W-1:0] push_col;
   logic [31:0] status_w;

   always_comb begin
      settled = settle_q == SW'(SETTLE_CYCLES);
      busy_cmd = !cmd_cs_n && !(cmd_ras_n && cmd_cas_n && cmd_we_n);
      is_rw = busy_cmd && cmd_ras_n && !cmd_cas_n;
      apb_wr = psel && penable && pwrite && pready_q;
      dpd_w = apb_wr && paddr == lpddr_pkg::OFS_CTRL
              && pwdata[lpddr_pkg::CTRL_DPD];
      st_clr = apb_wr && paddr == lpddr_pkg::OFS_STATUS;
      mode_base_w = settled && cmd_cke && busy_cmd && !cmd_ras_n
                    && !cmd_cas_n && !cmd_we_n && !cmd_bsh && !cmd_bsl;
      mode_ext_w = settled && cmd_cke && busy_cmd && !cmd_ras_n
                   && !cmd_cas_n && !cmd_we_n && cmd_bsh && !cmd_bsl;
      // burst only once init is complete and length code is legal
      start_burst = settled && cmd_cke && is_rw && init_q == init_ready
                    && burst_q == burst_idle
                    && bl_len(mode_q[2:0]) != 5'h00;
      push_w = burst_q == burst_run && fifo_in_ready;
      push_col = beat_col(start_q, blen_q, ilv_q, beat_q);
   end

   // init tracking and mode registers
   always_comb begin
      settle_d = settled ? settle_q : settle_q + SW'(1);
      init_d = init_q;
      pre_d = pre_q;
      ref_d = ref_q;
      base_d = base_q;
      ext_d = ext_q;
      mode_d = mode_q;
      emode_d = emode_q;
      if (settled && cmd_cke && busy_cmd) begin
         if (!cmd_ras_n && cmd_cas_n && !cmd_we_n
             && cmd_addr[lpddr_pkg::AP_BIT]) begin
            pre_d = 1'b1;
         end
         // refresh counted whether before or after mode setting
         if (!cmd_ras_n && !cmd_cas_n && cmd_we_n && ref_q != 2'h3) begin
            ref_d = ref_q + 2'h1;
         end
      end
      if (mode_base_w) begin
         mode_d = cmd_addr;
         base_d = 1'b1;
      end
      if (mode_ext_w) begin
         emode_d = cmd_addr;
         ext_d = 1'b1;
      end
      // both registers must be programmed before commands count
      if (pre_q && ref_q >= 2'h2 && base_q && ext_q) begin
         init_d = init_ready;
      end
      // deep power down loses both registers and the sequence
      if (dpd_w) begin
         settle_d = '0;
         init_d = init_cold;
         pre_d = 1'b0;
         ref_d = 2'h0;
         base_d = 1'b0;
         ext_d = 1'b0;
         mode_d = ADDR_W'(lpddr_pkg::MODE_RST);
         emode_d = ADDR_W'(lpddr_pkg::MODE_RST);
      end
   end

   // burst sequencer and sticky flags; a new event beats a clear
   always_comb begin
      burst_d = burst_q;
      start_d = start_q;
      bank_d = bank_q;
      wr_d = wr_q;
      ilv_d = ilv_q;
      blen_d = blen_q;
      beat_d = beat_q;
      reject_d = reject_q && !(st_clr && pwdata[lpddr_pkg::ST_REJECT]);
      early_d = early_q && !(st_clr && pwdata[lpddr_pkg::ST_EARLY]);
      overrun_d = overrun_q && !(st_clr && pwdata[lpddr_pkg::ST_OVERRUN]);
      if (!settled && busy_cmd) begin
         early_d = 1'b1;
      end
      if (settled && cmd_cke && is_rw && !start_burst) begin
         if (burst_q == burst_run) begin
            overrun_d = 1'b1;
         end else begin
            reject_d = 1'b1;
         end
      end
      case (burst_q)
         burst_idle: begin
            if (start_burst) begin
               burst_d = burst_run;
               start_d = cmd_col;
               bank_d = {cmd_bsh, cmd_bsl};
               wr_d = !cmd_we_n;
               ilv_d = mode_q[lpddr_pkg::MR_BT];
               blen_d = bl_len(mode_q[2:0]);
               beat_d = 4'h0;
            end
         end
         burst_run: begin
            if (push_w) begin
               beat_d = beat_q + 4'h1;
               if (5'(beat_q) == blen_q - 5'h01) begin
                  burst_d = burst_idle;
               end
            end
         end
         default: burst_d = burst_idle;
      endcase
   end

   // register read data and answer
   always_comb begin
      status_w = '0;
      status_w[lpddr_pkg::ST_READY] = init_q == init_ready;
      status_w[lpddr_pkg::ST_BASE] = base_q;
      status_w[lpddr_pkg::ST_EXT] = ext_q;
      status_w[lpddr_pkg::ST_PRE] = pre_q;
      status_w[lpddr_pkg::ST_REF +: 2] = ref_q;
      status_w[lpddr_pkg::ST_REJECT] = reject_q;
      status_w[lpddr_pkg::ST_EARLY] = early_q;
      status_w[lpddr_pkg::ST_OVERRUN] = overrun_q;
      status_w[lpddr_pkg::ST_BUSY] = burst_q == burst_run;
      pready_d = psel && !penable;
      pslverr_d = 1'b0;
      prdata_d = '0;
      if (psel && !penable) begin
         if (paddr == lpddr_pkg::OFS_CTRL) begin
            prdata_d = '0;
         end else if (paddr == lpddr_pkg::OFS_STATUS) begin
            prdata_d = status_w;
         end else if (paddr == lpddr_pkg::OFS_MODE) begin
            prdata_d = 32'(mode_q);
         end else if (paddr == lpddr_pkg::OFS_EXT) begin
            prdata_d = 32'(emode_q);
         end else begin
            pslverr_d = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_q <= '0;
         init_q <= init_cold;
         burst_q <= burst_idle;
         pre_q <= 1'b0;
         ref_q <= 2'h0;
         base_q <= 1'b0;
         ext_q <= 1'b0;
         mode_q <= '0;
         emode_q <= '0;
         reject_q <= 1'b0;
         early_q <= 1'b0;
         overrun_q <= 1'b0;
         start_q <= '0;
         bank_q <= 2'h0;
         wr_q <= 1'b0;
         ilv_q <= 1'b0;
         blen_q <= 5'h00;
         beat_q <= 4'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         settle_q <= settle_d;
         init_q <= init_d;
         burst_q <= burst_d;
         pre_q <= pre_d;
         ref_q <= ref_d;
         base_q <= base_d;
         ext_q <= ext_d;
         mode_q <= mode_d;
         emode_q <= emode_d;
         reject_q <= reject_d;
         early_q <= early_d;
         overrun_q <= overrun_d;
         start_q <= start_d;
         bank_q <= bank_d;
         wr_q <= wr_d;
         ilv_q <= ilv_d;
         blen_q <= blen_d;
         beat_q <= beat_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   logic [FW-1:0] fifo_out;
   lpddr_col_fifo #(.W(FW), .DEPTH(lpddr_pkg::FIFO_DEPTH)) u_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(burst_q == burst_run),
      .in_ready(fifo_in_ready),
      .in_data({wr_q, bank_q, push_col}),
      .out_valid(col_valid),
      .out_ready(col_ready),
      .out_data(fifo_out)
   );
   assign {col_write, col_bank, col_addr} = fifo_out;

   // offset of the previous beat, for the order checks only
   logic [3:0] prev_off_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_off_q <= 4'h0;
      end else if (push_w) begin
         prev_off_q <= push_col[3:0];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence start_then_push_s;
      start_burst ##1 push_w;
   endsequence

   cmd_gate_a: assert property (
      start_burst |-> init_q == init_ready && base_q && pre_q)
      else $error("burst started before init complete");
   ready_modes_a: assert property (
      init_q == init_ready |-> base_q && ext_q && ref_q >= 2'h2)
      else $error("ready without both mode registers");
   base_load_a: assert property (
      mode_base_w && !dpd_w |=> mode_q == $past(cmd_addr))
      else $error("base mode register not loaded");
   mode_hold_a: assert property (
      !mode_base_w && !dpd_w |=> $stable(mode_q))
      else $error("base mode register changed");
   len_field_a: assert property (
      start_burst |=> blen_q == bl_len($past(mode_q[2:0]))
                      && ilv_q == $past(mode_q[lpddr_pkg::MR_BT]))
      else $error("burst fields not taken from mode register");
   len_legal_a: assert property (
      burst_q == burst_run |-> blen_q inside {5'h02, 5'h04, 5'h08, 5'h10})
      else $error("illegal burst length in use");
   first_beat_a: assert property (
      start_then_push_s |-> push_col == $past(cmd_col, 1))
      else $error("first beat is not the start column");
   block_wrap_a: assert property (
      push_w |-> (push_col & ~COL_W'(off_mask(blen_q)))
                 == (start_q & ~COL_W'(off_mask(blen_q))))
      else $error("burst left its aligned block");
   seq_step_a: assert property (
      push_w && beat_q != 4'h0 && !ilv_q |->
         (push_col[3:0] & off_mask(blen_q))
         == (4'(prev_off_q + 4'h1) & off_mask(blen_q)))
      else $error("sequential step wrong");
   ilv_step_a: assert property (
      push_w && beat_q != 4'h0 && ilv_q |->
         ((push_col[3:0] ^ prev_off_q) & off_mask(blen_q))
         == ((beat_q ^ 4'(beat_q - 4'h1)) & off_mask(blen_q)))
      else $error("interleaved step wrong");
endmodule // lpddr_init_mode_burst
`default_nettype wire

/* logic/lpddr_pkg.sv */
/*
 * Shared constants for the mode-register and burst-address block:
 * register offsets, field positions, encodings and timing counts.
 * Assumes a 25 MHz register clock and a 32-bit APB register bus.
 */
package lpddr_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int SETTLE_TIME_US = 200;
   localparam int SETTLE_CYC =
      (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // APB byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [7:0] OFS_EXT = 8'h0C;
   // control and status bits
   localparam int CTRL_DPD = 0;
   localparam int ST_READY = 0;
   localparam int ST_BASE = 1;
   localparam int ST_EXT = 2;
   localparam int ST_PRE = 3;
   localparam int ST_REF = 4;
   localparam int ST_REJECT = 6;
   localparam int ST_EARLY = 7;
   localparam int ST_OVERRUN = 8;
   localparam int ST_BUSY = 9;
   // mode register fields and codes
   localparam int MR_BT = 3;
   localparam int MR_CL = 4;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_16 = 3'h4;
   localparam int AP_BIT = 10;
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   // column fifo
   localparam int FIFO_DEPTH = 32;
endpackage
